// ---- design/msfh_pkg.sv ----
// msfh_pkg: shared constants and the frame checksum step
// assumes a 20 MHz system clock and a 9600 baud, 10-bit serial character
package msfh_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int BAUD = 9600;
	localparam int BITS_PER_CHAR = 10;
	localparam int CHAR_CYCLES = (CLK_HZ * BITS_PER_CHAR + BAUD - 1) / BAUD;
	// idle gap of 3.5 characters, held as seven half characters
	localparam int GAP_HALF_CHARS = 7;
	localparam int GAP_CYCLES = (CLK_HZ * BITS_PER_CHAR * GAP_HALF_CHARS + 2 * BAUD - 1) / (2 * BAUD);
	localparam int RSP_TIMEOUT_MS = 100;
	localparam int RSP_TIMEOUT_CYCLES = CLK_HZ / 1000 * RSP_TIMEOUT_MS;
	localparam logic [8:0] MAX_FRAME_LEN = 9'h100;
	localparam logic [8:0] TCP_HDR_LEN = 9'h006;
	localparam logic [8:0] CRC_LEN = 9'h002;
	localparam logic [8:0] MIN_RTU_LEN = 9'h004;
	localparam logic [8:0] PL_SHORT = 9'h006;
	localparam logic [8:0] PL_MULTI_HDR = 9'h007;
	localparam logic [8:0] PL_MASK = 9'h008;
	localparam logic [7:0] LEN_BYTE_POS = 8'h05;
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX = 8'hf7;
	localparam logic [3:0] ADDR_SW_SOFT = 4'hf;
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_RD_INPUT = 8'h04;
	localparam logic [7:0] FC_WR_SINGLE = 8'h06;
	localparam logic [7:0] FC_WR_MULTI = 8'h10;
	localparam logic [7:0] FC_MASK_WR = 8'h16;
	localparam logic [15:0] RD_MAX = 16'h007d;
	localparam logic [15:0] WR_MAX = 16'h007b;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;

	// one message byte folded into the checksum, right-shifting form
	function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		logic lsb;
		r = c ^ {8'h00, d};
		for (int j = 0; j < 8; j++) begin
			lsb = r[0];
			r = r >> 1;
			if (lsb) begin
				r = r ^ CRC_POLY;
			end
		end
		return r;
	endfunction
endpackage

// ---- design/msfh_link_if.sv ----
// msfh_link_if: byte stream between master and slave
// assumes both ends share clk; one strobe per character on each direction
interface msfh_link_if;
	logic reqValid;
	logic [7:0] reqByte;
	logic rspValid;
	logic [7:0] rspByte;
	modport slave(input reqValid, input reqByte, output rspValid, output rspByte);
	modport master(output reqValid, output reqByte, input rspValid, input rspByte);
endinterface

// ---- design/msfh_slave.sv ----
// msfh_slave: slave end, receives requests, drives register port, answers
// assumes register read data follows regAddr within the same cycle
// Behaviour
// - frames hold at most 256 bytes
// - frames separated by 3.5 character idle gap
// - address 1 to 247, then function code
// - multi-byte fields and checksum sent high first
// - address matches switch, or soft address at F
// - one response frame per accepted request
// - tcp: six-byte header, no checksum
// - tcp: transaction identifier echoed unchanged
// - master sends protocol identifier zero
// - checksum from ffff, right shift, poly a001
// - checksum appended, mismatch means corrupted frame
// - code 3 reads 1-125 registers
// - code 4 handled like code 3
// - code 6 writes one register, echoes
// - code 16 writes 1-123 registers
// - code 22 merges keep mask and set value
// - mask write response equals the request
module msfh_slave #(
	parameter int CHAR_CYCLES = msfh_pkg::CHAR_CYCLES,
	parameter int GAP_CYCLES = msfh_pkg::GAP_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link to master
	msfh_link_if.slave link,
	// configuration
	input wire logic tcpMode,
	input wire logic [3:0] addrSwitch,
	input wire logic [7:0] softAddr,
	// register port
	output logic [15:0] regAddr,
	output logic regWrEn,
	output logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	// status
	output logic frameDrop
);
	typedef enum logic [3:0] {D_RX, D_CRC, D_DEC, D_RDHI, D_RDLO, D_WR, D_MW, D_FIN, D_TX} msfh_dstate_t;

	logic [7:0] frameBuf [0:255];
	msfh_dstate_t state, next_state;
	logic [8:0] rxCount, next_rxCount;
	logic [31:0] gapCnt, next_gapCnt;
	logic synced, next_synced;
	logic bad, next_bad;
	logic [8:0] idx, next_idx;
	logic [15:0] crc, next_crc;
	logic txPhase, next_txPhase;
	logic [15:0] start, next_start;
	logic [15:0] cnt, next_cnt;
	logic [15:0] keepMask, next_keepMask;
	logic [15:0] setVal, next_setVal;
	logic [7:0] rdLo, next_rdLo;
	logic [8:0] txLen, next_txLen;
	logic txCrc, next_txCrc;
	logic [8:0] txIdx, next_txIdx;
	logic [31:0] spaceCnt, next_spaceCnt;
	logic [15:0] next_regAddr;
	logic next_regWrEn;
	logic [15:0] next_regWrData;
	logic next_frameDrop;
	logic next_rspValid;
	logic [7:0] next_rspByte;
	logic bufWe;
	logic [7:0] bufWa;
	logic [7:0] bufWd;

	always_comb begin
		logic drop;
		logic gapOk;
		logic addrOk;
		logic [8:0] base;
		logic [7:0] b8;
		logic [8:0] pl;
		logic [8:0] crcEnd;
		logic [8:0] pos;
		logic [8:0] total;
		logic [7:0] target;
		logic [7:0] fc;
		drop = 1'b0;
		gapOk = gapCnt >= 32'(GAP_CYCLES);
		base = tcpMode ? msfh_pkg::TCP_HDR_LEN : 9'h000;
		b8 = base[7:0];
		pl = rxCount - base - (tcpMode ? 9'h000 : msfh_pkg::CRC_LEN);
		crcEnd = txPhase ? txLen : rxCount - msfh_pkg::CRC_LEN;
		pos = 9'h000;
		total = txLen + (txCrc ? msfh_pkg::CRC_LEN : 9'h000);
		target = (addrSwitch == msfh_pkg::ADDR_SW_SOFT) ? softAddr : {4'h0, addrSwitch};
		addrOk = frameBuf[b8] == target && frameBuf[b8] >= msfh_pkg::ADDR_MIN
			&& frameBuf[b8] <= msfh_pkg::ADDR_MAX;
		fc = frameBuf[b8 + 8'h01];
		next_state = state;
		next_rxCount = rxCount;
		next_gapCnt = gapCnt;
		next_synced = synced;
		next_bad = bad;
		next_idx = idx;
		next_crc = crc;
		next_txPhase = txPhase;
		next_start = start;
		next_cnt = cnt;
		next_keepMask = keepMask;
		next_setVal = setVal;
		next_rdLo = rdLo;
		next_txLen = txLen;
		next_txCrc = txCrc;
		next_txIdx = txIdx;
		next_spaceCnt = spaceCnt;
		next_regAddr = regAddr;
		next_regWrEn = 1'b0;
		next_regWrData = regWrData;
		next_frameDrop = 1'b0;
		next_rspValid = 1'b0;
		next_rspByte = link.rspByte;
		bufWe = 1'b0;
		bufWa = 8'h00;
		bufWd = 8'h00;
		// idle time since the last character in either direction
		if (link.reqValid || link.rspValid) begin
			next_gapCnt = 32'h0;
		end else if (!gapOk) begin
			next_gapCnt = gapCnt + 32'h1;
		end
		case (state)
			D_RX: begin
				if (link.reqValid) begin
					if (rxCount == msfh_pkg::MAX_FRAME_LEN) begin
						next_bad = 1'b1;
					end else begin
						bufWe = 1'b1;
						bufWa = rxCount[7:0];
						bufWd = link.reqByte;
						next_rxCount = rxCount + 9'h001;
					end
					if (!tcpMode && !synced) begin
						next_bad = 1'b1;
					end
				end else if (tcpMode) begin
					if (rxCount >= msfh_pkg::TCP_HDR_LEN
						&& (bad || rxCount == msfh_pkg::TCP_HDR_LEN + {1'b0, frameBuf[msfh_pkg::LEN_BYTE_POS]})) begin
						if (bad || rxCount == msfh_pkg::TCP_HDR_LEN) begin
							drop = 1'b1;
						end else begin
							next_state = D_DEC;
						end
					end
				end else if (gapOk) begin
					next_synced = 1'b1;
					if (rxCount != 9'h000) begin
						if (bad || rxCount < msfh_pkg::MIN_RTU_LEN) begin
							drop = 1'b1;
						end else begin
							next_state = D_CRC;
							next_idx = 9'h000;
							next_crc = msfh_pkg::CRC_INIT;
							next_txPhase = 1'b0;
						end
					end
				end
			end
			D_CRC: begin
				if (idx < crcEnd) begin
					next_crc = msfh_pkg::crcByte(crc, frameBuf[idx[7:0]]);
					next_idx = idx + 9'h001;
				end else if (txPhase) begin
					next_state = D_TX;
					next_txIdx = 9'h000;
					next_spaceCnt = 32'h0;
				end else if (crc == {frameBuf[crcEnd[7:0]], frameBuf[crcEnd[7:0] + 8'h01]}) begin
					next_state = D_DEC;
				end else begin
					drop = 1'b1;
				end
			end
			D_DEC: begin
				next_start = {frameBuf[b8 + 8'h02], frameBuf[b8 + 8'h03]};
				next_cnt = {frameBuf[b8 + 8'h04], frameBuf[b8 + 8'h05]};
				next_keepMask = {frameBuf[b8 + 8'h04], frameBuf[b8 + 8'h05]};
				next_setVal = {frameBuf[b8 + 8'h06], frameBuf[b8 + 8'h07]};
				next_regAddr = {frameBuf[b8 + 8'h02], frameBuf[b8 + 8'h03]};
				next_idx = 9'h000;
				next_txCrc = 1'b0;
				next_txLen = rxCount;
				if (!addrOk) begin
					drop = 1'b1;
				end else begin
					case (fc)
						msfh_pkg::FC_RD_HOLD, msfh_pkg::FC_RD_INPUT: begin
							if (pl == msfh_pkg::PL_SHORT && next_cnt != 16'h0 && next_cnt <= msfh_pkg::RD_MAX) begin
								bufWe = 1'b1;
								bufWa = b8 + 8'h02;
								bufWd = {next_cnt[6:0], 1'b0};
								next_txLen = base + 9'h003 + {next_cnt[7:0], 1'b0};
								next_txCrc = 1'b1;
								next_state = D_RDHI;
							end else begin
								drop = 1'b1;
							end
						end
						msfh_pkg::FC_WR_SINGLE: begin
							if (pl == msfh_pkg::PL_SHORT) begin
								next_regWrEn = 1'b1;
								next_regWrData = next_keepMask;
								next_state = D_FIN;
							end else begin
								drop = 1'b1;
							end
						end
						msfh_pkg::FC_WR_MULTI: begin
							if (pl == msfh_pkg::PL_MULTI_HDR + {1'b0, frameBuf[b8 + 8'h06]}
								&& {8'h00, frameBuf[b8 + 8'h06]} == {next_cnt[14:0], 1'b0}
								&& next_cnt != 16'h0 && next_cnt <= msfh_pkg::WR_MAX) begin
								next_txLen = base + 9'h006;
								next_txCrc = 1'b1;
								next_state = D_WR;
							end else begin
								drop = 1'b1;
							end
						end
						msfh_pkg::FC_MASK_WR: begin
							if (pl == msfh_pkg::PL_MASK) begin
								next_state = D_MW;
							end else begin
								drop = 1'b1;
							end
						end
						default: begin
							drop = 1'b1;
						end
					endcase
				end
			end
			D_RDHI: begin
				pos = base + 9'h003 + {idx[7:0], 1'b0};
				bufWe = 1'b1;
				bufWa = pos[7:0];
				bufWd = regRdData[15:8];
				next_rdLo = regRdData[7:0];
				next_state = D_RDLO;
			end
			D_RDLO: begin
				pos = base + 9'h004 + {idx[7:0], 1'b0};
				bufWe = 1'b1;
				bufWa = pos[7:0];
				bufWd = rdLo;
				next_idx = idx + 9'h001;
				next_regAddr = start + {7'h00, idx} + 16'h0001;
				next_state = ({7'h00, idx} + 16'h0001 == cnt) ? D_FIN : D_RDHI;
			end
			D_WR: begin
				pos = base + 9'h007 + {idx[7:0], 1'b0};
				next_regWrEn = 1'b1;
				next_regAddr = start + {7'h00, idx};
				next_regWrData = {frameBuf[pos[7:0]], frameBuf[pos[7:0] + 8'h01]};
				next_idx = idx + 9'h001;
				if ({7'h00, idx} + 16'h0001 == cnt) begin
					next_state = D_FIN;
				end
			end
			D_MW: begin
				next_regWrEn = 1'b1;
				next_regWrData = (regRdData & keepMask) | (setVal & ~keepMask);
				next_state = D_FIN;
			end
			D_FIN: begin
				next_txIdx = 9'h000;
				next_spaceCnt = 32'h0;
				if (tcpMode) begin
					// identifiers stay as received; only the count is rewritten
					bufWe = 1'b1;
					bufWa = msfh_pkg::LEN_BYTE_POS;
					bufWd = 8'(txLen - msfh_pkg::TCP_HDR_LEN);
					next_txCrc = 1'b0;
					next_state = D_TX;
				end else if (txCrc) begin
					next_idx = 9'h000;
					next_crc = msfh_pkg::CRC_INIT;
					next_txPhase = 1'b1;
					next_state = D_CRC;
				end else begin
					next_state = D_TX;
				end
			end
			D_TX: begin
				if (spaceCnt != 32'h0) begin
					next_spaceCnt = spaceCnt - 32'h1;
				end else if (txIdx == total) begin
					next_state = D_RX;
					next_rxCount = 9'h000;
					next_bad = 1'b0;
				end else if (tcpMode || txIdx != 9'h000 || gapOk) begin
					next_rspValid = 1'b1;
					if (txIdx < txLen) begin
						next_rspByte = frameBuf[txIdx[7:0]];
					end else if (txIdx == txLen) begin
						next_rspByte = crc[15:8];
					end else begin
						next_rspByte = crc[7:0];
					end
					next_txIdx = txIdx + 9'h001;
					next_spaceCnt = 32'(CHAR_CYCLES - 1);
				end
			end
			default: begin
				next_state = D_RX;
			end
		endcase
		if (drop) begin
			next_state = D_RX;
			next_rxCount = 9'h000;
			next_bad = 1'b0;
			next_frameDrop = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (bufWe) begin
			frameBuf[bufWa] <= bufWd;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= D_RX;
			rxCount <= 9'h000;
			gapCnt <= 32'h0;
			synced <= 1'b0;
			bad <= 1'b0;
			idx <= 9'h000;
			crc <= msfh_pkg::CRC_INIT;
			txPhase <= 1'b0;
			start <= 16'h0;
			cnt <= 16'h0;
			keepMask <= 16'h0;
			setVal <= 16'h0;
			rdLo <= 8'h00;
			txLen <= 9'h000;
			txCrc <= 1'b0;
			txIdx <= 9'h000;
			spaceCnt <= 32'h0;
			regAddr <= 16'h0;
			regWrEn <= 1'b0;
			regWrData <= 16'h0;
			frameDrop <= 1'b0;
			link.rspValid <= 1'b0;
			link.rspByte <= 8'h00;
		end else begin
			state <= next_state;
			rxCount <= next_rxCount;
			gapCnt <= next_gapCnt;
			synced <= next_synced;
			bad <= next_bad;
			idx <= next_idx;
			crc <= next_crc;
			txPhase <= next_txPhase;
			start <= next_start;
			cnt <= next_cnt;
			keepMask <= next_keepMask;
			setVal <= next_setVal;
			rdLo <= next_rdLo;
			txLen <= next_txLen;
			txCrc <= next_txCrc;
			txIdx <= next_txIdx;
			spaceCnt <= next_spaceCnt;
			regAddr <= next_regAddr;
			regWrEn <= next_regWrEn;
			regWrData <= next_regWrData;
			frameDrop <= next_frameDrop;
			link.rspValid <= next_rspValid;
			link.rspByte <= next_rspByte;
		end
	end
endmodule

// ---- design/msfh_master.sv ----
// msfh_master: master end, builds one request, collects the answer
// assumes request inputs stay stable while busy; valData follows valIdx
module msfh_master #(
	parameter int CHAR_CYCLES = msfh_pkg::CHAR_CYCLES,
	parameter int GAP_CYCLES = msfh_pkg::GAP_CYCLES,
	parameter int TIMEOUT_CYCLES = msfh_pkg::RSP_TIMEOUT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link to slave
	msfh_link_if.master link,
	// request
	input wire logic tcpMode,
	input wire logic startReq,
	input wire logic [7:0] slaveAddr,
	input wire logic [7:0] func,
	input wire logic [15:0] regStart,
	input wire logic [15:0] regCount,
	input wire logic [15:0] wordA,
	input wire logic [15:0] wordB,
	input wire logic [15:0] transId,
	output logic [6:0] valIdx,
	input wire logic [15:0] valData,
	// result
	output logic busy,
	output logic done,
	output logic rspOk,
	output logic [8:0] rspLen,
	input wire logic [7:0] rspIdx,
	output logic [7:0] rspByte
);
	typedef enum logic [2:0] {H_IDLE, H_BUILD, H_CRC, H_TX, H_RX, H_CHK} msfh_hstate_t;

	logic [7:0] frameBuf [0:255];
	msfh_hstate_t state, next_state;
	logic [8:0] idx, next_idx;
	logic [8:0] txLen, next_txLen;
	logic [8:0] rxCount, next_rxCount;
	logic [15:0] crc, next_crc;
	logic [31:0] gapCnt, next_gapCnt;
	logic [31:0] waitCnt, next_waitCnt;
	logic [6:0] next_valIdx;
	logic next_busy, next_done, next_rspOk;
	logic [8:0] next_rspLen;
	logic next_reqValid;
	logic [7:0] next_reqByte;
	logic bufWe;
	logic [7:0] bufWa, bufWd;

	always_comb begin
		logic gapOk, fc16, fc22;
		logic [8:0] base, body, p, p1, crcEnd, total;
		gapOk = gapCnt >= 32'(GAP_CYCLES);
		fc16 = func == msfh_pkg::FC_WR_MULTI;
		fc22 = func == msfh_pkg::FC_MASK_WR;
		base = tcpMode ? msfh_pkg::TCP_HDR_LEN : 9'h000;
		body = fc16 ? msfh_pkg::PL_MULTI_HDR + {regCount[7:0], 1'b0} : fc22 ? msfh_pkg::PL_MASK : msfh_pkg::PL_SHORT;
		p = idx - base;
		p1 = idx + 9'h001 - base;
		crcEnd = (rxCount < msfh_pkg::MIN_RTU_LEN) ? 9'h000 : rxCount - msfh_pkg::CRC_LEN;
		total = txLen + (tcpMode ? 9'h000 : msfh_pkg::CRC_LEN);
		next_state = state;
		next_idx = idx;
		next_txLen = txLen;
		next_rxCount = rxCount;
		next_crc = crc;
		next_gapCnt = gapCnt;
		next_waitCnt = waitCnt;
		next_valIdx = valIdx;
		next_busy = busy;
		next_done = 1'b0;
		next_rspOk = rspOk;
		next_rspLen = rspLen;
		next_reqValid = 1'b0;
		next_reqByte = link.reqByte;
		bufWe = 1'b0;
		bufWa = idx[7:0];
		bufWd = 8'h00;
		if (link.reqValid || link.rspValid) begin
			next_gapCnt = 32'h0;
		end else if (!gapOk) begin
			next_gapCnt = gapCnt + 32'h1;
		end
		case (state)
			H_IDLE: begin
				if (startReq) begin
					next_state = H_BUILD;
					next_busy = 1'b1;
					next_idx = 9'h000;
					next_valIdx = 7'h00;
					next_txLen = base + body;
				end
			end
			H_BUILD: begin
				bufWe = 1'b1;
				if (tcpMode && idx < msfh_pkg::TCP_HDR_LEN) begin
					// header: transaction id, protocol id zero, length
					case (idx[2:0])
						3'h0: bufWd = transId[15:8];
						3'h1: bufWd = transId[7:0];
						3'h5: bufWd = body[7:0];
						default: bufWd = 8'h00;
					endcase
				end else begin
					case (p)
						9'h000: bufWd = slaveAddr;
						9'h001: bufWd = func;
						9'h002: bufWd = regStart[15:8];
						9'h003: bufWd = regStart[7:0];
						9'h004: bufWd = fc16 ? regCount[15:8] : (fc22 || func == msfh_pkg::FC_WR_SINGLE) ? wordA[15:8] : regCount[15:8];
						9'h005: bufWd = fc16 ? regCount[7:0] : (fc22 || func == msfh_pkg::FC_WR_SINGLE) ? wordA[7:0] : regCount[7:0];
						9'h006: bufWd = fc16 ? {regCount[6:0], 1'b0} : wordB[15:8];
						9'h007: bufWd = fc16 ? valData[15:8] : wordB[7:0];
						default: bufWd = p[0] ? valData[15:8] : valData[7:0];
					endcase
				end
				next_idx = idx + 9'h001;
				if (p1 >= msfh_pkg::PL_MULTI_HDR) begin
					next_valIdx = 7'((p1 - msfh_pkg::PL_MULTI_HDR) >> 1);
				end
				if (idx + 9'h001 == txLen) begin
					next_idx = 9'h000;
					next_crc = msfh_pkg::CRC_INIT;
					next_state = tcpMode ? H_TX : H_CRC;
				end
			end
			H_CRC: begin
				if (idx < txLen) begin
					next_crc = msfh_pkg::crcByte(crc, frameBuf[idx[7:0]]);
					next_idx = idx + 9'h001;
				end else begin
					next_idx = 9'h000;
					next_waitCnt = 32'h0;
					next_state = H_TX;
				end
			end
			H_TX: begin
				if (waitCnt != 32'h0) begin
					next_waitCnt = waitCnt - 32'h1;
				end else if (idx == total) begin
					next_state = H_RX;
					next_rxCount = 9'h000;
				end else if (tcpMode || idx != 9'h000 || gapOk) begin
					next_reqValid = 1'b1;
					next_reqByte = (idx < txLen) ? frameBuf[idx[7:0]] : (idx == txLen) ? crc[15:8] : crc[7:0];
					next_idx = idx + 9'h001;
					next_waitCnt = 32'(CHAR_CYCLES - 1);
				end
			end
			H_RX: begin
				next_waitCnt = waitCnt + 32'h1;
				if (link.rspValid) begin
					next_waitCnt = 32'h0;
					if (rxCount != msfh_pkg::MAX_FRAME_LEN) begin
						bufWe = 1'b1;
						bufWa = rxCount[7:0];
						bufWd = link.rspByte;
						next_rxCount = rxCount + 9'h001;
					end
				end else if (rxCount == 9'h000) begin
					if (waitCnt >= 32'(TIMEOUT_CYCLES)) begin
						next_state = H_CHK;
					end
				end else if (tcpMode ? rxCount == msfh_pkg::TCP_HDR_LEN + {1'b0, frameBuf[msfh_pkg::LEN_BYTE_POS]}
					: gapOk) begin
					next_idx = 9'h000;
					next_crc = msfh_pkg::CRC_INIT;
					next_state = H_CHK;
				end
			end
			H_CHK: begin
				if (!tcpMode && idx < crcEnd) begin
					next_crc = msfh_pkg::crcByte(crc, frameBuf[idx[7:0]]);
					next_idx = idx + 9'h001;
				end else begin
					next_state = H_IDLE;
					next_busy = 1'b0;
					next_done = 1'b1;
					next_rspLen = rxCount;
					if (tcpMode) begin
						next_rspOk = rxCount > msfh_pkg::TCP_HDR_LEN + 9'h001 && {frameBuf[0], frameBuf[1]} == transId
							&& frameBuf[7] == func;
					end else begin
						next_rspOk = rxCount >= msfh_pkg::MIN_RTU_LEN && frameBuf[0] == slaveAddr
							&& frameBuf[1] == func && crc == {frameBuf[crcEnd[7:0]], frameBuf[crcEnd[7:0] + 8'h01]};
					end
				end
			end
			default: begin
				next_state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (bufWe) begin
			frameBuf[bufWa] <= bufWd;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= H_IDLE;
			idx <= 9'h000;
			txLen <= 9'h000;
			rxCount <= 9'h000;
			crc <= msfh_pkg::CRC_INIT;
			gapCnt <= 32'h0;
			waitCnt <= 32'h0;
			valIdx <= 7'h00;
			busy <= 1'b0;
			done <= 1'b0;
			rspOk <= 1'b0;
			rspLen <= 9'h000;
			rspByte <= 8'h00;
			link.reqValid <= 1'b0;
			link.reqByte <= 8'h00;
		end else begin
			state <= next_state;
			idx <= next_idx;
			txLen <= next_txLen;
			rxCount <= next_rxCount;
			crc <= next_crc;
			gapCnt <= next_gapCnt;
			waitCnt <= next_waitCnt;
			valIdx <= next_valIdx;
			busy <= next_busy;
			done <= next_done;
			rspOk <= next_rspOk;
			rspLen <= next_rspLen;
			rspByte <= frameBuf[rspIdx];
			link.reqValid <= next_reqValid;
			link.reqByte <= next_reqByte;
		end
	end
endmodule

// ---- sim/msfh_link_monitor.sv ----
// msfh_link_monitor: assertions on the byte link between the two ends
// assumes inputs tap the link interface, the shared clk, rst and tcpMode
module msfh_link_monitor #(
	parameter int CHAR_CYCLES = 4,
	parameter int GAP_CYCLES = 14
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link
	input wire logic reqValid,
	input wire logic [7:0] reqByte,
	input wire logic rspValid,
	input wire logic [7:0] rspByte,
	// mode
	input wire logic tcpMode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [16:0] idle;
	logic [8:0] n;
	logic lastReq;
	logic [7:0] q [8];
	logic [15:0] c0, c1, c2;
	logic [7:0] b1, b2, l5;
	wire logic anyV = reqValid | rspValid;
	wire logic newF = (reqValid & ~lastReq) | (rspValid & lastReq) | (idle >= 17'(GAP_CYCLES));
	wire logic [8:0] pos = newF ? 9'h0 : n;
	wire logic [7:0] d = reqValid ? reqByte : rspByte;
	wire logic [8:0] hdr = tcpMode ? 9'h6 : 9'h0;

	function automatic logic [15:0] crcf(input logic [15:0] c, input logic [7:0] v);
		c = c ^ {8'h00, v};
		for (int j = 0; j < 8; j++) begin
			c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle <= '1;
			n <= '0;
			lastReq <= 1'b0;
			c0 <= '1;
			c1 <= '1;
			c2 <= '1;
			b1 <= '0;
			b2 <= '0;
			l5 <= '0;
		end else begin
			idle <= anyV ? '0 : idle + 17'(idle != '1);
			if (anyV) begin
				lastReq <= reqValid;
				n <= pos + 9'h1;
				c0 <= crcf(newF ? 16'hffff : c0, d);
				c1 <= newF ? 16'hffff : c0;
				c2 <= newF ? 16'hffff : c1;
				b2 <= b1;
				b1 <= d;
				if (reqValid && pos < 9'h8) q[pos[2:0]] <= reqByte;
				if (rspValid && pos == 9'h5) l5 <= rspByte;
			end
		end
	end

	sequence rtuEnd;
		!tcpMode && !lastReq && !anyV && idle == 17'(GAP_CYCLES - 1) && n >= 9'h4;
	endsequence
	sequence tcpEnd;
		tcpMode && !lastReq && !anyV && idle == 17'(GAP_CYCLES - 1) && n >= 9'h7;
	endsequence

	chk_frame_len: assert property (anyV |-> pos < 9'h100)
		else $error("frame longer than 256 bytes");
	chk_rsp_gap: assert property (rspValid && lastReq && !tcpMode |-> idle >= 17'(GAP_CYCLES - 1))
		else $error("response without idle gap");
	chk_req_gap: assert property (reqValid && !lastReq && !tcpMode |-> idle >= 17'(GAP_CYCLES - 1))
		else $error("request without idle gap");
	chk_char_space: assert property (rspValid && !lastReq |-> idle >= 17'(CHAR_CYCLES - 1))
		else $error("response characters too close");
	chk_no_collide: assert property (rspValid |-> !reqValid)
		else $error("both directions at once");
	chk_rsp_addr: assert property (rspValid && pos == hdr |-> rspByte inside {[8'h01:8'hf7]})
		else $error("response address out of range");
	chk_echo_hdr: assert property (rspValid && pos < hdr + 9'h2 && pos != 9'h4 && pos != 9'h5 |-> rspByte == q[pos[2:0]])
		else $error("response header differs from request");
	chk_rtu_crc: assert property (rtuEnd |-> {b2, b1} == c2)
		else $error("response checksum wrong");
	chk_tcp_len: assert property (tcpEnd |-> n == 9'h6 + {1'b0, l5})
		else $error("tcp length field wrong");
endmodule

// ---- sim/modbus_slave_frame_handler_tb.sv ----
// modbus_slave_frame_handler_tb: master and slave joined, requests checked end to end
// assumes shortened character and gap counts on both ends, and a shortened timeout count on the master
module modbus_slave_frame_handler_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CC = 4;
	localparam int GC = 14;
	logic clk = 0, rst = 1, tcpMode = 0, startReq = 0;
	logic [3:0] addrSwitch = 4'h5;
	logic [7:0] softAddr = 8'h2a, slaveAddr = 0, func = 0, rspIdx = 0, rspByte;
	logic [15:0] regStart = 0, regCount = 0, wordA = 0, wordB = 0, transId = 0;
	logic [15:0] regAddr, regWrData;
	logic [15:0] mem [16] = '{default: 16'h0};
	logic regWrEn, frameDrop, busy, done, rspOk;
	logic [6:0] valIdx;
	logic [8:0] rspLen;
	int error_cnt = 0, num_checks = 0, drops = 0;
	msfh_link_if link ();
	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (regWrEn === 1'b1) mem[regAddr[3:0]] <= regWrData;
		if (frameDrop === 1'b1) drops <= drops + 1;
	end
	msfh_slave #(.CHAR_CYCLES(CC), .GAP_CYCLES(GC)) u_msfh_slave (.clk(clk), .rst(rst), .link(link),
		.tcpMode(tcpMode), .addrSwitch(addrSwitch), .softAddr(softAddr), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdData(mem[regAddr[3:0]]), .frameDrop(frameDrop));
	msfh_master #(.CHAR_CYCLES(CC), .GAP_CYCLES(GC), .TIMEOUT_CYCLES(2000)) u_msfh_master (.clk(clk), .rst(rst),
		.link(link), .tcpMode(tcpMode), .startReq(startReq), .slaveAddr(slaveAddr), .func(func),
		.regStart(regStart), .regCount(regCount), .wordA(wordA), .wordB(wordB), .transId(transId),
		.valIdx(valIdx), .valData({9'h000, valIdx} ^ 16'hc300), .busy(busy), .done(done), .rspOk(rspOk),
		.rspLen(rspLen), .rspIdx(rspIdx), .rspByte(rspByte));
	msfh_link_monitor #(.CHAR_CYCLES(CC), .GAP_CYCLES(GC)) u_msfh_link_monitor (.clk(clk), .rst(rst),
		.reqValid(link.reqValid), .reqByte(link.reqByte), .rspValid(link.rspValid), .rspByte(link.rspByte),
		.tcpMode(tcpMode));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic req(input logic [7:0] sa, fc, input logic [15:0] st, cn, a, b);
		@(posedge clk);
		slaveAddr <= sa;
		func <= fc;
		regStart <= st;
		regCount <= cn;
		wordA <= a;
		wordB <= b;
		transId <= transId + 16'h1111;
		startReq <= 1'b1;
		@(posedge clk);
		startReq <= 1'b0;
		for (int i = 0; i < 5000 && done !== 1'b1; i++) @(posedge clk);
	endtask
	task automatic fin(input logic o, input logic [8:0] len);
		check({15'h0, rspOk}, {15'h0, o});
		check({7'h0, rspLen}, {7'h0, len});
		check({15'h0, busy}, 16'h0);
	endtask
	task automatic cb(input logic [7:0] i, input logic [7:0] exp);
		@(posedge clk);
		rspIdx <= i;
		repeat (2) @(posedge clk);
		check({8'h00, rspByte}, {8'h00, exp});
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		req(8'h05, 8'h06, 16'h3, 16'h1, 16'hbeef, 16'h0);
		fin(1'b1, 9'h8);
		check(mem[3], 16'hbeef);
		cb(8'h4, 8'hbe);
		req(8'h05, 8'h16, 16'h3, 16'h0, 16'h0f0f, 16'h1234);
		fin(1'b1, 9'ha);
		check(mem[3], 16'h1e3f);
		cb(8'h6, 8'h12);
		cb(8'h7, 8'h34);
		req(8'h05, 8'h10, 16'h8, 16'h3, 16'h0, 16'h0);
		fin(1'b1, 9'h8);
		check(mem[9], 16'hc301);
		cb(8'h5, 8'h03);
		req(8'h05, 8'h03, 16'h8, 16'h3, 16'h0, 16'h0);
		fin(1'b1, 9'hb);
		cb(8'h2, 8'h06);
		cb(8'h8, 8'h02);
		req(8'h05, 8'h04, 16'h3, 16'h1, 16'h0, 16'h0);
		fin(1'b1, 9'h7);
		cb(8'h1, 8'h04);
		cb(8'h4, 8'h3f);
		req(8'h05, 8'h03, 16'h0, 16'd125, 16'h0, 16'h0);
		fin(1'b1, 9'hff);
		cb(8'h2, 8'hfa);
		req(8'h05, 8'h03, 16'h0, 16'd126, 16'h0, 16'h0);
		fin(1'b0, 9'h0);
		req(8'h06, 8'h06, 16'h1, 16'h1, 16'h0055, 16'h0);
		fin(1'b0, 9'h0);
		addrSwitch <= 4'hf;
		req(8'h2a, 8'h06, 16'h1, 16'h1, 16'h0055, 16'h0);
		fin(1'b1, 9'h8);
		check(mem[1], 16'h0055);
		req(8'h2a, 8'h05, 16'h1, 16'h1, 16'h0, 16'h0);
		fin(1'b0, 9'h0);
		req(8'h05, 8'h06, 16'h1, 16'h1, 16'h0066, 16'h0);
		fin(1'b0, 9'h0);
		check(16'(drops), 16'h4);
		rst <= 1'b1;
		tcpMode <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		req(8'h2a, 8'h03, 16'h8, 16'h2, 16'h0, 16'h0);
		fin(1'b1, 9'hd);
		cb(8'h0, transId[15:8]);
		cb(8'h1, transId[7:0]);
		cb(8'h5, 8'h07);
		cb(8'h6, 8'h2a);
		repeat (20) @(posedge clk);
		report_and_stop();
	end
endmodule
